// ==== logic/transition_filter_defines.vh ====
`ifndef TRANSITION_FILTER_DEFINES_VH
`define TRANSITION_FILTER_DEFINES_VH

// register selectors on the command port
`define SEL_MEAS_RISE 4'h0
`define SEL_MEAS_FALL 4'h1
`define SEL_QUES_RISE 4'h2
`define SEL_OPER_RISE 4'h3
`define SEL_TRIG_RISE 4'h4
`define SEL_ARM_RISE 4'h5
`define SEL_SEQ_RISE 4'h6
`define SEL_MEAS_ENABLE 4'h7
`define SEL_MEAS_EVENT 4'h8
`define SEL_MEAS_COND 4'h9
`define SEL_PRESET 4'hA

// measurement event bit positions
`define BIT_OVER_RANGE 0
`define BIT_FIRST_LOWER 1
`define BIT_FIRST_UPPER 2
`define BIT_SECOND_LOWER 3
`define BIT_SECOND_UPPER 4
`define BIT_READING_READY 5
`define BIT_UNDER_RANGE 6
`define BIT_BUFFER_DATA 7
`define BIT_BUFFER_HALF 8
`define BIT_BUFFER_FULL 9
`define BIT_PRETRIGGER 11
`define BIT_NOISE_SPIKE 12
`define BIT_COMPLIANCE 14

// assigned measurement positions; B10, B13 and B15 are unassigned
`define MEAS_VALID_BITS 16'h5BFF

// reset values
`define MEAS_RISE_RESET 16'h5BFF
`define MEAS_FALL_RESET 16'h0000
`define GROUP_RISE_RESET 16'hFFFF
`define MEAS_ENABLE_RESET 16'h0000

`endif

// ==== logic/measurement_transition_filter.v ====
// Notes on behaviour
// - rising means condition went zero to one
// - enabled rising transition sets event bit
// - mask value is weighted bit sum
// - six groups each keep rising mask
// - rising mask one enables, zero disables
// - falling mask one enables, zero disables
// - over range condition drives bit B0
// - first lower limit drives bit B1
// - first upper limit drives bit B2
// - second lower limit drives bit B3
// - second upper limit drives bit B4
// - reading ready drives bit B5
// - reading under range drives bit B6
// - buffer has data drives bit B7
// - buffer half drives bit B8
// - buffer full drives bit B9
// - buffer pretrigger drives bit B11
// - noise spike drives bit B12
// - source compliance drives bit B14
// - enable mask gates event to summary
`timescale 1ns/1ns
`include "transition_filter_defines.vh"

module measurement_transition_filter
(
  input wire ref_clk,
  input wire sys_rst,
  input wire reading_over_range,
  input wire first_lower_limit,
  input wire first_upper_limit,
  input wire second_lower_limit,
  input wire second_upper_limit,
  input wire reading_ready,
  input wire reading_under_range,
  input wire buffer_has_data,
  input wire buffer_half,
  input wire buffer_full_flag,
  input wire buffer_pretrigger,
  input wire noise_spike_flag,
  input wire source_compliance,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [3:0] cmd_sel,
  input wire [15:0] cmd_value,
  output reg reply_valid,
  output reg [15:0] reply_value,
  output reg measurement_summary,
  output reg [15:0] questionable_rising_mask,
  output reg [15:0] operation_rising_mask,
  output reg [15:0] trigger_rising_mask,
  output reg [15:0] arm_rising_mask,
  output reg [15:0] sequence_rising_mask
);

  wire [15:0] cond_raw;
  reg [15:0] cond_s1;
  reg [15:0] cond_s2;
  reg [15:0] cond_s3;
  reg [15:0] cond_now;
  reg [15:0] cond_last;
  reg [15:0] measurement_rising_mask;
  reg [15:0] measurement_falling_mask;
  reg [15:0] measurement_enable;
  reg [15:0] measurement_event;
  reg [15:0] next_event;
  reg [15:0] next_reply;
  wire [15:0] rise_bits;
  wire [15:0] fall_bits;
  wire [15:0] hit_bits;
  wire write_cmd;
  wire read_cmd;

  // only assigned positions are storable, the rest read back zero
  function [15:0] meas_field;
    input [15:0] value;
    begin
      meas_field = value & `MEAS_VALID_BITS;
    end
  endfunction

  assign cond_raw = {
    1'b0,
    source_compliance,
    1'b0,
    noise_spike_flag,
    buffer_pretrigger,
    1'b0,
    buffer_full_flag,
    buffer_half,
    buffer_has_data,
    reading_under_range,
    reading_ready,
    second_upper_limit,
    second_lower_limit,
    first_upper_limit,
    first_lower_limit,
    reading_over_range
  };

  assign write_cmd = cmd_valid & cmd_write;
  assign read_cmd = cmd_valid & ~cmd_write;

  // condition levels arrive from other logic; a change is accepted only
  // once the second and third stages agree, so one-cycle glitches vanish;
  // conditions already high at release count as rising, the stages start at zero
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cond_s1 <= 16'h0000;
      cond_s2 <= 16'h0000;
      cond_s3 <= 16'h0000;
      cond_now <= 16'h0000;
      cond_last <= 16'h0000;
    end
    else
    begin
      cond_s1 <= cond_raw;
      cond_s2 <= cond_s1;
      cond_s3 <= cond_s2;
      cond_now <= (cond_s2 & cond_s3) | (cond_now & (cond_s2 ^ cond_s3));
      cond_last <= cond_now;
    end
  end

  assign rise_bits = cond_now & ~cond_last & measurement_rising_mask;
  assign fall_bits = ~cond_now & cond_last & measurement_falling_mask;
  assign hit_bits = meas_field(rise_bits | fall_bits);

  // a hit in the clearing cycle survives, so no transition is lost
  // sticky, set wins
  always @*
  begin
    next_event = measurement_event;
    if (cmd_valid && (cmd_sel == `SEL_MEAS_EVENT))
    begin
      next_event = 16'h0000;
    end
    else if (write_cmd && (cmd_sel == `SEL_PRESET))
    begin
      next_event = 16'h0000;
    end
    next_event = next_event | hit_bits;
  end

  always @*
  begin
    next_reply = 16'h0000;
    if (cmd_sel == `SEL_MEAS_RISE)
    begin
      next_reply = meas_field(measurement_rising_mask);
    end
    else if (cmd_sel == `SEL_MEAS_FALL)
    begin
      next_reply = meas_field(measurement_falling_mask);
    end
    else if (cmd_sel == `SEL_QUES_RISE)
    begin
      next_reply = questionable_rising_mask;
    end
    else if (cmd_sel == `SEL_OPER_RISE)
    begin
      next_reply = operation_rising_mask;
    end
    else if (cmd_sel == `SEL_TRIG_RISE)
    begin
      next_reply = trigger_rising_mask;
    end
    else if (cmd_sel == `SEL_ARM_RISE)
    begin
      next_reply = arm_rising_mask;
    end
    else if (cmd_sel == `SEL_SEQ_RISE)
    begin
      next_reply = sequence_rising_mask;
    end
    else if (cmd_sel == `SEL_MEAS_ENABLE)
    begin
      next_reply = meas_field(measurement_enable);
    end
    else if (cmd_sel == `SEL_MEAS_EVENT)
    begin
      next_reply = measurement_event;
    end
    else if (cmd_sel == `SEL_MEAS_COND)
    begin
      next_reply = cond_now;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      measurement_rising_mask <= `MEAS_RISE_RESET;
      measurement_falling_mask <= `MEAS_FALL_RESET;
      measurement_enable <= `MEAS_ENABLE_RESET;
      questionable_rising_mask <= `GROUP_RISE_RESET;
      operation_rising_mask <= `GROUP_RISE_RESET;
      trigger_rising_mask <= `GROUP_RISE_RESET;
      arm_rising_mask <= `GROUP_RISE_RESET;
      sequence_rising_mask <= `GROUP_RISE_RESET;
    end
    else if (write_cmd)
    begin
      if (cmd_sel == `SEL_MEAS_RISE)
      begin
        measurement_rising_mask <= meas_field(cmd_value);
      end
      else if (cmd_sel == `SEL_MEAS_FALL)
      begin
        measurement_falling_mask <= meas_field(cmd_value);
      end
      else if (cmd_sel == `SEL_QUES_RISE)
      begin
        questionable_rising_mask <= cmd_value;
      end
      else if (cmd_sel == `SEL_OPER_RISE)
      begin
        operation_rising_mask <= cmd_value;
      end
      else if (cmd_sel == `SEL_TRIG_RISE)
      begin
        trigger_rising_mask <= cmd_value;
      end
      else if (cmd_sel == `SEL_ARM_RISE)
      begin
        arm_rising_mask <= cmd_value;
      end
      else if (cmd_sel == `SEL_SEQ_RISE)
      begin
        sequence_rising_mask <= cmd_value;
      end
      else if (cmd_sel == `SEL_MEAS_ENABLE)
      begin
        measurement_enable <= meas_field(cmd_value);
      end
      else if (cmd_sel == `SEL_PRESET)
      begin
        // preset restores every mask to its power-on pattern
        measurement_rising_mask <= `MEAS_RISE_RESET;
        measurement_falling_mask <= `MEAS_FALL_RESET;
        measurement_enable <= `MEAS_ENABLE_RESET;
        questionable_rising_mask <= `GROUP_RISE_RESET;
        operation_rising_mask <= `GROUP_RISE_RESET;
        trigger_rising_mask <= `GROUP_RISE_RESET;
        arm_rising_mask <= `GROUP_RISE_RESET;
        sequence_rising_mask <= `GROUP_RISE_RESET;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      measurement_event <= 16'h0000;
      measurement_summary <= 1'b0;
      reply_valid <= 1'b0;
      reply_value <= 16'h0000;
    end
    else
    begin
      measurement_event <= next_event;
      measurement_summary <= |(next_event & measurement_enable);
      reply_valid <= read_cmd;
      // reply holds its last value so the host may sample late
      if (read_cmd)
      begin
        reply_value <= next_reply;
      end
    end
  end

endmodule

// ==== dv/transition_filter_props.sv ====
`timescale 1ns/1ns
`include "transition_filter_defines.vh"
module transition_filter_props
(
  input wire ref_clk,
  input wire sys_rst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [3:0] cmd_sel,
  input wire [15:0] cmd_value,
  input wire reply_valid,
  input wire [15:0] reply_value,
  input wire [15:0] questionable_rising_mask,
  input wire [15:0] operation_rising_mask,
  input wire [15:0] trigger_rising_mask,
  input wire [15:0] arm_rising_mask,
  input wire [15:0] sequence_rising_mask
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence query_taken;
    cmd_valid && !cmd_write;
  endsequence
  sequence write_to(logic [3:0] s);
    cmd_valid && cmd_write && cmd_sel == s;
  endsequence
  reply_after_query_a: assert property (query_taken |=> reply_valid)
    else $error("query gave no reply");
  reply_cause_a: assert property (reply_valid |-> $past(cmd_valid && !cmd_write))
    else $error("reply without query");
  reply_hold_a: assert property (!reply_valid |-> $stable(reply_value))
    else $error("reply value moved without reply");
  unmapped_zero_a: assert property (query_taken ##0 cmd_sel > `SEL_PRESET |=> !reply_value)
    else $error("unmapped query not zero");
  ques_write_a: assert property (write_to(`SEL_QUES_RISE)
    |=> questionable_rising_mask == $past(cmd_value)) else $error("ques mask write lost");
  seq_write_a: assert property (write_to(`SEL_SEQ_RISE)
    |=> sequence_rising_mask == $past(cmd_value)) else $error("seq mask write lost");
  arm_hold_a: assert property (!(cmd_valid && cmd_write) |=> $stable(arm_rising_mask))
    else $error("arm mask moved without write");
  preset_masks_a: assert property (write_to(`SEL_PRESET) |=>
    trigger_rising_mask == `GROUP_RISE_RESET && operation_rising_mask == `GROUP_RISE_RESET)
    else $error("preset left group masks");
endmodule
bind measurement_transition_filter transition_filter_props props_u (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
  .cmd_value(cmd_value), .reply_valid(reply_valid), .reply_value(reply_value),
  .questionable_rising_mask(questionable_rising_mask),
  .operation_rising_mask(operation_rising_mask), .trigger_rising_mask(trigger_rising_mask),
  .arm_rising_mask(arm_rising_mask), .sequence_rising_mask(sequence_rising_mask));

// ==== dv/measurement_transition_filter_bench.sv ====
`timescale 1ns/1ns
`include "transition_filter_defines.vh"
`define CHK(nm, e, g) begin check_count = check_count + 1; if ((g) !== (e)) begin \
  mismatches = mismatches + 1; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module measurement_transition_filter_bench;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg cmd_valid = 1'b0;
  reg cmd_write = 1'b0;
  reg [3:0] cmd_sel = 4'h0;
  reg [15:0] cmd_value = 16'h0000;
  reg [15:0] cond = 16'h0000;
  wire reply_valid;
  wire [15:0] reply_value;
  wire summary;
  wire [15:0] ques;
  wire [15:0] oper;
  wire [15:0] trig;
  wire [15:0] arm;
  wire [15:0] seqm;
  integer mismatches = 0;
  integer check_count = 0;
  integer i;
  reg [35:0] rows [0:11];
  measurement_transition_filter dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reading_over_range(cond[0]), .first_lower_limit(cond[1]), .first_upper_limit(cond[2]),
    .second_lower_limit(cond[3]), .second_upper_limit(cond[4]), .reading_ready(cond[5]),
    .reading_under_range(cond[6]), .buffer_has_data(cond[7]), .buffer_half(cond[8]),
    .buffer_full_flag(cond[9]), .buffer_pretrigger(cond[11]), .noise_spike_flag(cond[12]),
    .source_compliance(cond[14]), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_value(cmd_value), .reply_valid(reply_valid),
    .reply_value(reply_value), .measurement_summary(summary),
    .questionable_rising_mask(ques), .operation_rising_mask(oper),
    .trigger_rising_mask(trig), .arm_rising_mask(arm), .sequence_rising_mask(seqm));
  always #5 ref_clk = ~ref_clk;
  task final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmd(input w, input [3:0] s, input [15:0] v);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = s;
    cmd_value = v;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask
  // reply is registered on the taking edge itself, so it is settled at this falling edge
  task ask(input [3:0] s, input [15:0] e);
    cmd(1'b0, s, 16'h0000);
    `CHK("reply_valid", 1'b1, reply_valid)
    `CHK("reply_value", e, reply_value)
  endtask
  // the condition path needs five edges; eight leaves margin for the synchroniser
  task settle;
    repeat (8) @(negedge ref_clk);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    rows[0] = {`SEL_MEAS_RISE, 16'h0000, 16'h0000};
    rows[1] = {`SEL_MEAS_RISE, 16'hFFFF, 16'h5BFF};
    rows[2] = {`SEL_MEAS_FALL, 16'h0220, 16'h0220};
    rows[3] = {`SEL_MEAS_FALL, 16'hFFFF, 16'h5BFF};
    rows[4] = {`SEL_QUES_RISE, 16'hFFFF, 16'hFFFF};
    rows[5] = {`SEL_OPER_RISE, 16'h1234, 16'h1234};
    rows[6] = {`SEL_TRIG_RISE, 16'h0002, 16'h0002};
    rows[7] = {`SEL_ARM_RISE, 16'h0002, 16'h0002};
    rows[8] = {`SEL_SEQ_RISE, 16'h0006, 16'h0006};
    rows[9] = {`SEL_MEAS_ENABLE, 16'hFFFF, 16'h5BFF};
    rows[10] = {4'hB, 16'h1234, 16'h0000};
    rows[11] = {4'hF, 16'hFFFF, 16'h0000};
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    ask(`SEL_MEAS_RISE, `MEAS_RISE_RESET);
    ask(`SEL_MEAS_FALL, `MEAS_FALL_RESET);
    ask(`SEL_MEAS_ENABLE, `MEAS_ENABLE_RESET);
    `CHK("ques_reset", `GROUP_RISE_RESET, ques)
    for (i = 0; i < 12; i = i + 1)
    begin
      cmd(1'b1, rows[i][35:32], rows[i][31:16]);
      ask(rows[i][35:32], rows[i][15:0]);
    end
    `CHK("oper_mask", 16'h1234, oper)
    `CHK("trig_mask", 16'h0002, trig)
    `CHK("arm_mask", 16'h0002, arm)
    cmd(1'b1, `SEL_MEAS_FALL, 16'h0000);
    ask(`SEL_MEAS_EVENT, 16'h0000);
    for (i = 0; i < 16; i = i + 1)
    begin
      if (`MEAS_VALID_BITS >> i & 1)
      begin
        cond[i] = 1'b1;
        settle;
        `CHK("summary", 1'b1, summary)
        ask(`SEL_MEAS_COND, 16'h0001 << i);
        ask(`SEL_MEAS_EVENT, 16'h0001 << i);
        cond[i] = 1'b0;
        settle;
        ask(`SEL_MEAS_EVENT, 16'h0000);
      end
    end
    cmd(1'b1, `SEL_MEAS_RISE, 16'h0020);
    cmd(1'b1, `SEL_MEAS_FALL, 16'h0200);
    cmd(1'b1, `SEL_MEAS_ENABLE, 16'h0020);
    cond = 16'h0220;
    settle;
    ask(`SEL_MEAS_EVENT, 16'h0020);
    ask(`SEL_MEAS_EVENT, 16'h0000);
    cond = 16'h0000;
    settle;
    `CHK("masked_summary", 1'b0, summary)
    ask(`SEL_MEAS_EVENT, 16'h0200);
    cmd(1'b1, `SEL_QUES_RISE, 16'h1234);
    cmd(1'b1, `SEL_PRESET, 16'h0000);
    `CHK("ques_preset", `GROUP_RISE_RESET, ques)
    ask(`SEL_MEAS_RISE, `MEAS_RISE_RESET);
    cmd(1'b1, `SEL_SEQ_RISE, 16'h0001);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    `CHK("seq_reset", `GROUP_RISE_RESET, seqm)
    final_report;
  end
endmodule
